/* File: hdl/wdm_top.sv */
// Watchdog mode control with AHB-Lite register access.
//
// Notes on behaviour
// - Watchdog interrupt request needs both interrupt enable and global enable high.
// - Interrupt enable alone gives interrupt mode, flag on each time-out, no reset.
// - Both enables give interrupt-then-reset mode; first time-out sets the flag.
// - Taking the vector there clears interrupt enable and flag, leaving reset mode.
// - In that mode a second time-out with the flag still pending resets the system.
// - Clock monitoring forces reset mode and disables the interrupt mode.
// - With clock monitoring, reset mode needs fuse, reset enable or interrupt enable.
// - The unlock clears itself four clock cycles after it was written.
// - Reset enable reads and acts as one while the reset cause flag is set.
// - Period code 0 gives 2048 oscillator cycles, doubling up to code 9.
// - The force-on fuse holds reset mode, reset enable one, interrupt enable zero.
// - In reset mode an unrestarted time-out issues a system reset.
// - The time-out flag clears on vector execution or on a written one.
`timescale 1ns/100ps
`include "wdm_map.svh"

module wdm_top
   import wdm_pkg::*;
#(
   parameter int BASE_CYCLES = `WDM_BASE_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic osc_clk,
   input wire logic clock_monitor_on,
   input wire logic force_on_fuse,
   input wire logic global_irq_enable,
   input wire logic vector_taken,
   output logic wdt_irq,
   output logic sys_reset,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic osc_meta_reg, osc_sync_reg, osc_last_reg;
   logic mon_meta_reg, mon_sync_reg, fuse_meta_reg, fuse_sync_reg;
   logic osc_edge;
   logic dphase_reg, dwrite_reg;
   logic [7:0] daddr_reg;
   logic hreadyout_reg, hresp_reg, wdt_irq_reg, sys_reset_reg, irq_reg;
   logic [31:0] hrdata_reg;
   logic bus_wr;
   logic timeout_flag_reg, irq_en_reg, reset_enable_reg, change_unlock_reg;
   logic [1:0] unlock_cnt_reg;
   logic [3:0] period_select_reg;
   logic cause_flag_reg;
   logic [`WDM_EV_W-1:0] irq_stat_reg, irq_mask_reg, events;
   logic [`WDM_CNT_W-1:0] count_reg, limit;
   logic [3:0] sel_eff;
   logic reset_enable_eff, irq_en_eff, running, timeout, restart;
   logic protected_ok, unlock_open, ctrl_wr;
   logic [7:0] ctrl_read;
   wdm_mode_t mode;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pins from outside the clock domain; the edge detector reads
   // the second and third stages so a metastable first stage never reaches logic.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_last_reg <= 1'b0;
         mon_meta_reg <= 1'b0;
         mon_sync_reg <= 1'b0;
         fuse_meta_reg <= 1'b0;
         fuse_sync_reg <= 1'b0;
      end else begin
         osc_meta_reg <= osc_clk;
         osc_sync_reg <= osc_meta_reg;
         osc_last_reg <= osc_sync_reg;
         mon_meta_reg <= clock_monitor_on;
         mon_sync_reg <= mon_meta_reg;
         fuse_meta_reg <= force_on_fuse;
         fuse_sync_reg <= fuse_meta_reg;
      end
   end

   assign osc_edge = osc_sync_reg && !osc_last_reg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Effective enables and mode selection.
   assign reset_enable_eff = reset_enable_reg || cause_flag_reg || fuse_sync_reg;
   assign irq_en_eff = irq_en_reg && !fuse_sync_reg && !mon_sync_reg;

   always_comb begin
      if (mon_sync_reg) begin
         if (fuse_sync_reg || reset_enable_eff || irq_en_reg) begin
            mode = WDM_RESET_MODE;
         end else begin
            mode = WDM_STOPPED;
         end
      end else if (fuse_sync_reg) begin
         mode = WDM_RESET_MODE;
      end else begin
         case ({reset_enable_eff, irq_en_reg})
            2'h1: mode = WDM_IRQ_MODE;
            2'h2: mode = WDM_RESET_MODE;
            2'h3: mode = WDM_IRQ_RESET_MODE;
            default: mode = WDM_STOPPED;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Time-out counter on oscillator edges; reserved codes act as the longest period.
   assign sel_eff = (period_select_reg > `WDM_SEL_MAX) ? `WDM_SEL_MAX : period_select_reg;
   assign limit = `WDM_CNT_W'(BASE_CYCLES) << sel_eff;
   assign running = (mode != WDM_STOPPED);
   assign timeout = running && osc_edge && (count_reg == limit - `WDM_CNT_W'(1));
   assign restart = bus_wr && (daddr_reg == `WDM_OFF_RESTART);

   // A stopped watchdog holds its count at zero so it restarts a full period.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         count_reg <= '0;
      end else if (!running || restart || timeout) begin
         count_reg <= '0;
      end else if (osc_edge) begin
         count_reg <= count_reg + `WDM_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: every transfer takes one wait state so read data come from a flop.
   assign bus_wr = dphase_reg && dwrite_reg;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         dphase_reg <= 1'b0;
         dwrite_reg <= 1'b0;
         daddr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else if (hsel && htrans[1] && hready) begin
         dphase_reg <= 1'b1;
         dwrite_reg <= hwrite;
         daddr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
         hreadyout_reg <= 1'b0;
      end else begin
         dphase_reg <= 1'b0;
         hreadyout_reg <= 1'b1;
      end
   end

   assign ctrl_read = {timeout_flag_reg, irq_en_eff, period_select_reg[3], change_unlock_reg,
                       reset_enable_eff, period_select_reg[2:0]};

   // Read data; unmapped offsets read as zero.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hrdata_reg <= 32'h00000000;
      end else if (dphase_reg && !dwrite_reg) begin
         case (daddr_reg)
            `WDM_OFF_CTRL: hrdata_reg <= {24'h000000, ctrl_read};
            `WDM_OFF_IRQ_STAT: hrdata_reg <= {30'h00000000, irq_stat_reg};
            `WDM_OFF_IRQ_MASK: hrdata_reg <= {30'h00000000, irq_mask_reg};
            `WDM_OFF_RST_STAT: hrdata_reg <= {31'h00000000, cause_flag_reg};
            `WDM_OFF_MODE: hrdata_reg <= {30'h00000000, mode};
            default: hrdata_reg <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Control register and timed unlock. Clearing the reset enable and changing the
   // period are honoured only while the unlock is open and the write leaves it clear.
   assign ctrl_wr = bus_wr && (daddr_reg == `WDM_OFF_CTRL);
   assign protected_ok = ctrl_wr && change_unlock_reg && !hwdata[`WDM_CTL_CU];
   assign unlock_open = ctrl_wr && hwdata[`WDM_CTL_CU] && hwdata[`WDM_CTL_RE];

   // The unlock cannot be re-armed while open, so its window is always four cycles.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         change_unlock_reg <= 1'b0;
         unlock_cnt_reg <= 2'h0;
      end else if (change_unlock_reg) begin
         unlock_cnt_reg <= unlock_cnt_reg - 2'h1;
         if (unlock_cnt_reg == 2'h0) begin
            change_unlock_reg <= 1'b0;
         end
      end else if (unlock_open) begin
         change_unlock_reg <= 1'b1;
         unlock_cnt_reg <= `WDM_UNLOCK_LAST;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         reset_enable_reg <= `WDM_RESET_ENABLE_INIT;
         period_select_reg <= 4'h0;
      end else if (ctrl_wr) begin
         // A pending reset cause blocks clearing the stored enable, so it keeps its value once the cause clears.
         if (hwdata[`WDM_CTL_RE]) begin
            reset_enable_reg <= 1'b1;
         end else if (protected_ok && !cause_flag_reg) begin
            reset_enable_reg <= 1'b0;
         end
         if (protected_ok) begin
            period_select_reg <= {hwdata[`WDM_CTL_P3], hwdata[`WDM_CTL_PLO_MSB:0]};
         end
      end
   end

   // The hardware clear on vector entry wins over a write in the same cycle.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq_en_reg <= 1'b0;
      end else if (vector_taken && mode == WDM_IRQ_RESET_MODE) begin
         irq_en_reg <= 1'b0;
      end else if (ctrl_wr) begin
         irq_en_reg <= hwdata[`WDM_CTL_IE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Time-out flag and system reset; a new time-out wins over any clear.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         timeout_flag_reg <= 1'b0;
         sys_reset_reg <= 1'b0;
      end else begin
         sys_reset_reg <= 1'b0;
         if (timeout && (mode == WDM_RESET_MODE ||
             (mode == WDM_IRQ_RESET_MODE && timeout_flag_reg))) begin
            sys_reset_reg <= 1'b1;
         end else if (timeout && mode != WDM_STOPPED) begin
            timeout_flag_reg <= 1'b1;
         end else if (vector_taken || (ctrl_wr && hwdata[`WDM_CTL_FLAG])) begin
            timeout_flag_reg <= 1'b0;
         end
      end
   end

   // Reset cause flag: set by a watchdog reset, cleared by writing zero to it.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cause_flag_reg <= 1'b0;
      end else if (sys_reset_reg) begin
         cause_flag_reg <= 1'b1;
      end else if (bus_wr && daddr_reg == `WDM_OFF_RST_STAT && !hwdata[`WDM_RST_CAUSE]) begin
         cause_flag_reg <= 1'b0;
      end
   end

   // Request to the processor only while flag, enable and global enable are all set.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wdt_irq_reg <= 1'b0;
      end else begin
         wdt_irq_reg <= timeout_flag_reg && irq_en_eff && global_irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Bus interrupt: sticky events, write one to clear, mask gates the output.
   assign events[`WDM_EV_TIMEOUT] = timeout && running;
   assign events[`WDM_EV_RESET] = sys_reset_reg;

   for (genvar i = 0; i < `WDM_EV_W; i++) begin : g_ev
      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            irq_stat_reg[i] <= 1'b0;
         end else if (events[i]) begin
            irq_stat_reg[i] <= 1'b1;
         end else if (bus_wr && daddr_reg == `WDM_OFF_IRQ_STAT && hwdata[i]) begin
            irq_stat_reg[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq_mask_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         if (bus_wr && daddr_reg == `WDM_OFF_IRQ_MASK) begin
            irq_mask_reg <= hwdata[`WDM_EV_W-1:0];
         end
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;
   assign wdt_irq = wdt_irq_reg;
   assign sys_reset = sys_reset_reg;
   assign irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence unlock_start_s;
      !change_unlock_reg ##1 change_unlock_reg;
   endsequence
   sequence unlock_window_s;
      change_unlock_reg [*4] ##1 !change_unlock_reg;
   endsequence

   irq_gate_a: assert property (wdt_irq_reg |-> $past(timeout_flag_reg) && $past(irq_en_eff)
      && $past(global_irq_enable))
      else $error("watchdog interrupt without both enables");
   unlock_close_a: assert property (unlock_start_s |-> unlock_window_s)
      else $error("unlock window not four cycles");
   irq_mode_a: assert property (timeout && mode == WDM_IRQ_MODE |=>
      timeout_flag_reg && !sys_reset_reg)
      else $error("interrupt mode time-out misbehaved");
   first_timeout_a: assert property (timeout && mode == WDM_IRQ_RESET_MODE && !timeout_flag_reg
      |=> timeout_flag_reg && !sys_reset_reg)
      else $error("first time-out did not set the flag");
   vector_clear_a: assert property (vector_taken && mode == WDM_IRQ_RESET_MODE && !timeout
      |=> !timeout_flag_reg && !irq_en_reg)
      else $error("vector did not clear flag and enable");
   second_timeout_a: assert property (timeout && mode == WDM_IRQ_RESET_MODE && timeout_flag_reg
      |=> sys_reset_reg ##1 cause_flag_reg)
      else $error("pending time-out did not reset");
   clock_monitor_a: assert property (mon_sync_reg && (irq_en_reg || reset_enable_eff)
      |-> mode == WDM_RESET_MODE && !irq_en_eff)
      else $error("clock monitor did not force reset mode");
   cause_override_a: assert property (cause_flag_reg |-> ctrl_read[`WDM_CTL_RE]
      && mode != WDM_STOPPED && mode != WDM_IRQ_MODE)
      else $error("reset enable not forced by cause flag");
   fuse_force_a: assert property (fuse_sync_reg |-> mode == WDM_RESET_MODE
      && !ctrl_read[`WDM_CTL_IE])
      else $error("fuse did not force reset mode");
   stopped_hold_a: assert property (mode == WDM_STOPPED |=> count_reg == '0
      && !sys_reset_reg)
      else $error("stopped watchdog counted");
   reset_mode_a: assert property (timeout && mode == WDM_RESET_MODE |=> sys_reset_reg)
      else $error("reset mode time-out gave no reset");
   flag_clear_a: assert property (ctrl_wr && hwdata[`WDM_CTL_FLAG] && !timeout
      |=> !timeout_flag_reg)
      else $error("written one did not clear the flag");

endmodule // wdm_top

/* File: hdl/wdm_map.svh */
// Register offsets, field positions, reset values and timing counts of the watchdog control block.
`ifndef WDM_MAP_SVH
`define WDM_MAP_SVH

`define WDM_OFF_CTRL 8'h00
`define WDM_OFF_IRQ_STAT 8'h04
`define WDM_OFF_IRQ_MASK 8'h08
`define WDM_OFF_RST_STAT 8'h0C
`define WDM_OFF_RESTART 8'h10
`define WDM_OFF_MODE 8'h14

`define WDM_CTL_FLAG 7
`define WDM_CTL_IE 6
`define WDM_CTL_P3 5
`define WDM_CTL_CU 4
`define WDM_CTL_RE 3
`define WDM_CTL_PLO_MSB 2
`define WDM_EV_TIMEOUT 0
`define WDM_EV_RESET 1
`define WDM_RST_CAUSE 0

`define WDM_EV_W 2
`define WDM_CNT_W 21
`define WDM_BASE_CYCLES 2048
`define WDM_SEL_MAX 4'h9
`define WDM_UNLOCK_LAST 2'h3
`define WDM_RESET_ENABLE_INIT 1'b0

`endif

/* File: hdl/wdm_pkg.sv */
// Types shared by the watchdog control block.
package wdm_pkg;
   typedef enum logic [1:0] {
      WDM_STOPPED,
      WDM_IRQ_MODE,
      WDM_RESET_MODE,
      WDM_IRQ_RESET_MODE
   } wdm_mode_t;
endpackage

/* File: test/wdm_test.sv */
// Self-checking bench for the watchdog mode control block.
`timescale 1ns/100ps
`include "wdm_map.svh"

module test_watchdog_mode_control
   import wdm_pkg::*;
;
   localparam int BASE = 4;
   localparam logic [31:0] A_CTL = 32'(`WDM_OFF_CTRL);
   localparam logic [31:0] A_IST = 32'(`WDM_OFF_IRQ_STAT);
   localparam logic [31:0] A_IMK = 32'(`WDM_OFF_IRQ_MASK);
   localparam logic [31:0] A_CAU = 32'(`WDM_OFF_RST_STAT);
   localparam logic [31:0] A_RSR = 32'(`WDM_OFF_RESTART);
   localparam logic [31:0] A_MOD = 32'(`WDM_OFF_MODE);
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic osc_clk = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic mon_on = 1'b0;
   logic fuse = 1'b0;
   logic gie = 1'b0;
   logic vec = 1'b0;
   logic hreadyout, hresp, wdt_irq, sys_reset, irq;
   logic [31:0] hrdata;
   logic [15:0] lfsr = 16'h33E1;
   logic [3:0] codes [4];
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   logic rd_dp = 1'b0;
   int fail_count = 0;
   int total_checks = 0;
   int rst_cnt = 0;
   int osc_cnt = 0;
   int oph = 0;

   // A short base count keeps every time-out within a few thousand cycles.
   wdm_top #(.BASE_CYCLES(BASE)) dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .osc_clk(osc_clk), .clock_monitor_on(mon_on), .force_on_fuse(fuse),
      .global_irq_enable(gie), .vector_taken(vec), .wdt_irq(wdt_irq),
      .sys_reset(sys_reset), .irq(irq));

   always #25 core_clk = ~core_clk;

   // The oscillator runs free at a quarter of the core rate, safely below half of it.
   always @(posedge core_clk) begin
      oph <= oph + 1;
      if (oph % 2 == 1) begin
         osc_clk <= ~osc_clk;
         if (!osc_clk) osc_cnt <= osc_cnt + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string what);
      total_checks++;
      if (!ok) begin
         fail_count++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic tmo();
      chk(1'b0, "wait ran out");
      final_report();
   endtask

   // Reads are compared by the monitor when their data phase completes.
   always @(posedge core_clk) begin
      if (sys_reset === 1'b1) rst_cnt <= rst_cnt + 1;
      if (rd_dp && hreadyout === 1'b1) begin
         chk((hrdata & msk_q.pop_front()) === exp_q.pop_front() && hresp === 1'b0, "read data");
         rd_dp = 1'b0;
      end
      if (hsel && htrans[1] && hreadyout === 1'b1 && !hwrite) rd_dp = 1'b1;
   end

   // One whole-word transfer; the address phase is held until ready is sampled high.
   task automatic xfer(input logic wr, input logic [31:0] a, d, e, m);
      int n;
      n = 0;
      if (!wr) begin
         exp_q.push_back(e);
         msk_q.push_back(m);
      end
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) tmo();
   endtask

   task automatic wr(input logic [31:0] a, d);
      xfer(1'b1, a, d, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [31:0] a, e, input logic [31:0] m = 32'hFFFFFFFF);
      xfer(1'b0, a, 32'h0, e, m);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Waits for the time-out interrupt line or for a reset pulse, never without bound.
   task automatic wait_sig(input logic irq_sel, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while ((irq_sel ? wdt_irq : sys_reset) !== 1'b1 && n < lim);
      if ((irq_sel ? wdt_irq : sys_reset) !== 1'b1) tmo();
   endtask

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Restart data is random; any value must restart the counter.
   task automatic kick();
      wr(A_RSR, {16'h0000, lfsr});
      lfsr = lfsr_next(lfsr);
   endtask

   function automatic logic [31:0] pcode(input logic [3:0] c);
      pcode = 32'h0;
      pcode[5] = c[3];
      pcode[2:0] = c[2:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int r0, o0, n, e;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      // Reset values, and unmapped places that read zero and ignore writes.
      rd(A_CTL, 32'h0);
      rd(A_MOD, 32'h0);
      wr(32'h18, 32'hFF);
      rd(32'h18, 32'h0);
      rd(32'h100, 32'h0);
      // Interrupt mode with the global enable low: the flag sets, the line stays low.
      wr(A_CTL, 32'h1A);
      wr(A_CTL, 32'h42);
      rd(A_CTL, 32'h42, 32'h7F);
      rd(A_MOD, 32'(WDM_IRQ_MODE));
      r0 = rst_cnt;
      idle(200);
      chk(wdt_irq === 1'b0, "irq without global enable");
      chk(rst_cnt == r0, "reset in interrupt mode");
      rd(A_CTL, 32'hC2);
      rd(A_IST, 32'h1, 32'h1);
      chk(irq === 1'b0, "masked event raised the line");
      gie <= 1'b1;
      idle(2);
      chk(wdt_irq === 1'b1, "irq with global enable");
      wr(A_IMK, 32'h1);
      idle(2);
      chk(irq === 1'b1, "unmasked event line low");
      kick();
      wr(A_IST, 32'h1);
      wr(A_CTL, 32'hC2);
      rd(A_CTL, 32'h42);
      chk(irq === 1'b0, "event line after clear");
      wr(A_IMK, 32'h0);
      // Interrupt-then-reset mode, with and without the vector being taken.
      wr(A_CTL, 32'h4A);
      rd(A_MOD, 32'(WDM_IRQ_RESET_MODE));
      r0 = rst_cnt;
      wait_sig(1'b1, 300);
      chk(rst_cnt == r0, "reset at first time-out");
      rd(A_CTL, 32'hCA);
      vec <= 1'b1;
      @(posedge core_clk);
      vec <= 1'b0;
      rd(A_CTL, 32'h0A);
      rd(A_MOD, 32'(WDM_RESET_MODE));
      wait_sig(1'b0, 300);
      rd(A_CAU, 32'h1);
      rd(A_IST, 32'h2, 32'h2);
      kick();
      wr(A_CTL, 32'h4A);
      wait_sig(1'b1, 400);
      wait_sig(1'b0, 400);
      // Time-out length for several codes, a random one and a reserved one among them.
      codes = '{4'h0, 4'h1, 4'h2 + {2'h0, lfsr[1:0]}, 4'hF};
      foreach (codes[i]) begin
         wr(A_CTL, pcode(codes[i]) | 32'h18);
         wr(A_CTL, pcode(codes[i]) | 32'h08);
         kick();
         o0 = osc_cnt;
         wait_sig(1'b0, 12000);
         n = osc_cnt - o0;
         e = BASE << ((codes[i] > 4'h9) ? 9 : codes[i]);
         chk(n >= e - 1 && n <= e + 1, "time-out length");
      end
      rd(A_CTL, 32'h2F, 32'h3F);
      // The cause flag pins the reset enable; the unlock window is short.
      kick();
      wr(A_CTL, 32'h3F);
      wr(A_CTL, 32'h27);
      rd(A_CTL, 32'h2F, 32'h7F);
      wr(A_CAU, 32'h0);
      rd(A_CAU, 32'h0);
      wr(A_CTL, 32'h27);
      rd(A_CTL, 32'h2F, 32'h7F);
      wr(A_CTL, 32'h3F);
      rd(A_CTL, 32'h3F, 32'h7F);
      idle(4);
      rd(A_CTL, 32'h2F, 32'h7F);
      wr(A_CTL, 32'h27);
      rd(A_CTL, 32'h2F, 32'h7F);
      wr(A_CTL, 32'h3F);
      wr(A_CTL, 32'h27);
      rd(A_CTL, 32'h27, 32'h7F);
      rd(A_MOD, 32'h0);
      r0 = rst_cnt;
      idle(200);
      chk(rst_cnt == r0 && wdt_irq === 1'b0, "stopped watchdog acted");
      // Fuse forces reset mode, clock monitor does so once an enable is set; both keep the interrupt enable off.
      fuse <= 1'b1;
      idle(4);
      rd(A_CTL, 32'h08, 32'h48);
      rd(A_MOD, 32'(WDM_RESET_MODE));
      fuse <= 1'b0;
      mon_on <= 1'b1;
      idle(4);
      rd(A_MOD, 32'h0);
      wr(A_CTL, 32'h67);
      rd(A_CTL, 32'h00, 32'h48);
      rd(A_MOD, 32'(WDM_RESET_MODE));
      kick();
      wait_sig(1'b0, 12000);
      final_report();
   end
endmodule // test_watchdog_mode_control
